// ---- rtl/rta_core.v ----
`timescale 1ns/10ps
`include "rta_defs.vh"

// Notes on behaviour
// - Time counters frozen during host access
// - Release counters and apply the pending tick on the same edge
// - One pending tick held, further ticks lost
// - Seconds alarm: enable low, BCD tens, units
// - Minutes alarm: enable low, BCD tens, units
// - Hours alarm: enable low, PM or tens
// - Hour field meaning follows hour format bit
// - Day alarm: enable low, BCD tens, units
// - Weekday alarm: enable low, code 0 to 6
// - All enabled fields match sets alarm flag
// - Disabled fields are left out of match
// - Flag holds until cleared, sets on new match
// - Interrupt pin active while flag set, if enabled
module rta_core
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Raw 1 Hz tick from the oscillator divider
  input wire tick_1hz_i,
  // Register port from the serial front end
  input wire access_active_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // Current BCD time fields from the counters
  input wire [7:0] time_sec_i,
  input wire [7:0] time_min_i,
  input wire [7:0] time_hr_i,
  input wire [7:0] time_date_i,
  input wire [7:0] time_dow_i,
  // Control bits held in the control registers
  input wire hour_12_mode_i,
  input wire alarm_irq_enable_i,
  input wire alarm_flag_clear_i,
  // Counter control towards the timekeeping counters
  output reg time_hold_o,
  output reg time_inc_o,
  // Alarm state and open-drain interrupt pin
  output reg alarm_flag_o,
  output reg int_o,
  output reg int_oe_n_o
);

  // Alarm compare registers
  reg [7:0] alarm_sec_compare; // Seconds alarm
  reg [7:0] alarm_min_compare; // Minutes alarm
  reg [7:0] alarm_hr_compare; // Hours alarm
  reg [7:0] alarm_date_compare; // Day alarm
  reg [7:0] alarm_dow_compare; // Weekday alarm

  // Tick handling
  wire tick_rise; // Synchronised tick edge
  reg inc_pending; // One stored tick while blocked
  reg access_prev; // Access level one cycle ago
  reg cmp_due; // Counters hold the new time now

  // Match network
  wire [7:0] hr_mask; // Hour compare bits for the current format
  wire [4:0] field_match; // Per-field agreement
  wire [4:0] field_active; // Per-field enable
  wire all_match; // Enabled fields all agree
  wire any_active; // At least one field enabled

  // Next values
  reg next_alarm_flag;
  reg [7:0] next_rdata;

  // Bring the tick into this clock and mark its rise
  rta_tick_sync u_tick_sync
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .tick_async_i(tick_1hz_i),
    .tick_rise_o(tick_rise)
  );

  // Counters stay frozen while the host access lasts
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      time_hold_o <= 1'b0;
      access_prev <= 1'b0;
    end
    else
    begin
      time_hold_o <= access_active_i;
      access_prev <= access_active_i;
    end
  end

  // Tick scheduling: pass through, hold one, or replay at release
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      inc_pending <= 1'b0;
      time_inc_o <= 1'b0;
    end
    else if (access_active_i)
    begin
      // No increment may reach the counters during an access
      time_inc_o <= 1'b0;
      // Only one tick fits; a second one is simply dropped
      if (tick_rise)
      begin
        inc_pending <= 1'b1;
      end
    end
    else if (access_prev && inc_pending)
    begin
      // Access just ended: serve the stored tick first
      time_inc_o <= 1'b1;
      // A fresh tick in this very cycle takes the pending slot
      inc_pending <= tick_rise;
    end
    else if (inc_pending)
    begin
      // Pending slot filled in the release cycle; serve it now
      time_inc_o <= 1'b1;
      inc_pending <= tick_rise;
    end
    else
    begin
      // Normal running: each tick goes straight out
      time_inc_o <= tick_rise;
    end
  end

  // The counters show the new time one cycle after the increment
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmp_due <= 1'b0;
    end
    else
    begin
      cmp_due <= time_inc_o;
    end
  end

  // Alarm register writes; unused bits are forced to zero
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_sec_compare <= `RTA_ALARM_RESET;
      alarm_min_compare <= `RTA_ALARM_RESET;
      alarm_hr_compare <= `RTA_ALARM_RESET;
      alarm_date_compare <= `RTA_ALARM_RESET;
      alarm_dow_compare <= `RTA_ALARM_RESET;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `RTA_OFS_ALARM_SEC:
        begin
          // Enable, three tens bits, four units bits
          alarm_sec_compare <= reg_wdata_i & `RTA_WMASK_SEC;
        end
        `RTA_OFS_ALARM_MIN:
        begin
          alarm_min_compare <= reg_wdata_i & `RTA_WMASK_MIN;
        end
        `RTA_OFS_ALARM_HR:
        begin
          // Bit 6 is unused and reads back as zero
          alarm_hr_compare <= reg_wdata_i & `RTA_WMASK_HR;
        end
        `RTA_OFS_ALARM_DATE:
        begin
          alarm_date_compare <= reg_wdata_i & `RTA_WMASK_DATE;
        end
        `RTA_OFS_ALARM_DOW:
        begin
          // Only the weekday code and the enable survive
          alarm_dow_compare <= reg_wdata_i & `RTA_WMASK_DOW;
        end
        default:
        begin
          // Other addresses belong to other blocks
          alarm_sec_compare <= alarm_sec_compare;
        end
      endcase
    end
  end

  // Read mux for the alarm bank
  always @*
  begin
    case (reg_addr_i)
      `RTA_OFS_ALARM_SEC: next_rdata = alarm_sec_compare;
      `RTA_OFS_ALARM_MIN: next_rdata = alarm_min_compare;
      `RTA_OFS_ALARM_HR: next_rdata = alarm_hr_compare;
      `RTA_OFS_ALARM_DATE: next_rdata = alarm_date_compare;
      `RTA_OFS_ALARM_DOW: next_rdata = alarm_dow_compare;
      default: next_rdata = `RTA_RDATA_NONE;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= `RTA_RDATA_NONE;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Hour compare follows the selected hour format
  assign hr_mask = hour_12_mode_i ? `RTA_CMASK_HR_12 :
    `RTA_CMASK_HR_24;

  // Seconds field compare
  rta_field_match #(.W(8)) u_match_sec
  (
    .alarm_i(alarm_sec_compare),
    .now_i(time_sec_i),
    .mask_i(`RTA_CMASK_SEC),
    .match_o(field_match[0]),
    .active_o(field_active[0])
  );

  // Minutes field compare
  rta_field_match #(.W(8)) u_match_min
  (
    .alarm_i(alarm_min_compare),
    .now_i(time_min_i),
    .mask_i(`RTA_CMASK_MIN),
    .match_o(field_match[1]),
    .active_o(field_active[1])
  );

  // Hours field compare
  rta_field_match #(.W(8)) u_match_hr
  (
    .alarm_i(alarm_hr_compare),
    .now_i(time_hr_i),
    .mask_i(hr_mask),
    .match_o(field_match[2]),
    .active_o(field_active[2])
  );

  // Day field compare
  rta_field_match #(.W(8)) u_match_date
  (
    .alarm_i(alarm_date_compare),
    .now_i(time_date_i),
    .mask_i(`RTA_CMASK_DATE),
    .match_o(field_match[3]),
    .active_o(field_active[3])
  );

  // Weekday field compare
  rta_field_match #(.W(8)) u_match_dow
  (
    .alarm_i(alarm_dow_compare),
    .now_i(time_dow_i),
    .mask_i(`RTA_CMASK_DOW),
    .match_o(field_match[4]),
    .active_o(field_active[4])
  );

  // Disabled fields report a match and so drop out
  assign all_match = &field_match;
  // With every field disabled there is no alarm at all
  assign any_active = |field_active;

  // Flag update: set only at a fresh one-second update
  always @*
  begin
    next_alarm_flag = alarm_flag_o;
    if (alarm_flag_clear_i)
    begin
      next_alarm_flag = 1'b0;
    end
    // Set beats clear so a match in the clear cycle is kept
    if (cmp_due && all_match && any_active)
    begin
      next_alarm_flag = 1'b1;
    end
  end

  // Flag and pin are registered together so they move in step
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_flag_o <= 1'b0;
      int_o <= 1'b0;
      int_oe_n_o <= 1'b1;
    end
    else
    begin
      alarm_flag_o <= next_alarm_flag;
      // Open drain: only ever drives low
      int_o <= 1'b0;
      int_oe_n_o <= ~(alarm_irq_enable_i & next_alarm_flag);
    end
  end

endmodule

// ---- rtl/rta_defs.vh ----
`ifndef RTA_DEFS_VH
`define RTA_DEFS_VH

// Register offsets of the alarm compare bank
`define RTA_OFS_ALARM_SEC 8'h0B
`define RTA_OFS_ALARM_MIN 8'h0C
`define RTA_OFS_ALARM_HR 8'h0D
`define RTA_OFS_ALARM_DATE 8'h0E
`define RTA_OFS_ALARM_DOW 8'h0F

// First and last offset of the blocked time counters
`define RTA_OFS_TIME_FIRST 8'h04
`define RTA_OFS_TIME_LAST 8'h0A

// Reset value of every alarm register: compare disabled, value zero
`define RTA_ALARM_RESET 8'h80

// Position of the active-low compare enable in every alarm register
`define RTA_BIT_MATCH_DISABLE 7

// Writable bits of each alarm register; unused bits stay zero
`define RTA_WMASK_SEC 8'hFF
`define RTA_WMASK_MIN 8'hFF
`define RTA_WMASK_HR 8'hBF
`define RTA_WMASK_DATE 8'hBF
`define RTA_WMASK_DOW 8'h87

// Bits taking part in each compare (BCD tens and units, weekday code)
`define RTA_CMASK_SEC 8'h7F
`define RTA_CMASK_MIN 8'h7F
`define RTA_CMASK_DATE 8'h3F
`define RTA_CMASK_DOW 8'h07

// Hour compare bits: PM flag, tens bit and units in 12 hour mode
`define RTA_CMASK_HR_12 8'h3F
// Hour compare bits: two tens bits and units in 24 hour mode
`define RTA_CMASK_HR_24 8'h3F

// Read answer for an address this block does not own
`define RTA_RDATA_NONE 8'h00

`endif

// ---- rtl/rta_tick_sync.v ----
`timescale 1ns/10ps
// Brings the 1 Hz tick from the oscillator domain and marks its rise
module rta_tick_sync
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Asynchronous tick level
  input wire tick_async_i,
  // One-cycle pulse on each rising edge of the tick
  output wire tick_rise_o
);

  reg sync_meta; // First stage, read only by the second
  reg sync_level; // Second stage, safe to use
  reg level_prev; // Delayed copy for edge detection

  // Two-stage synchroniser followed by an edge detector
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_meta <= 1'b0;
      sync_level <= 1'b0;
      level_prev <= 1'b0;
    end
    else
    begin
      sync_meta <= tick_async_i;
      sync_level <= sync_meta;
      level_prev <= sync_level;
    end
  end

  // Rise seen only after both stages
  assign tick_rise_o = sync_level & ~level_prev;

endmodule

// ---- rtl/rta_field_match.v ----
`timescale 1ns/10ps
// Compares one alarm field with one time field under a bit mask
module rta_field_match
#(
  parameter W = 8
)
(
  // Alarm register content, enable bit in the top position
  input wire [W-1:0] alarm_i,
  // Current time field
  input wire [W-1:0] now_i,
  // Bits that take part in the compare
  input wire [W-1:0] mask_i,
  // Field agrees, or is left out of the compare
  output wire match_o,
  // Field takes part in the compare
  output wire active_o
);

  wire equal; // Masked BCD digits agree

  assign equal = ((alarm_i & mask_i) == (now_i & mask_i));
  // A disabled field never blocks the overall match
  assign active_o = ~alarm_i[W-1];
  assign match_o = alarm_i[W-1] | equal;

endmodule

// ---- verification/rta_core_properties.sv ----
`timescale 1ns/10ps
// Port checks on counter blocking, register answers and alarm
module rta_core_properties
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Host side
  input wire access_active_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_rvalid_o,
  // Alarm controls and outputs
  input wire alarm_irq_enable_i,
  input wire alarm_flag_clear_i,
  input wire time_hold_o,
  input wire time_inc_o,
  input wire alarm_flag_o,
  input wire int_oe_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_hold_on_access: assert property (
    access_active_i |=> time_hold_o) else $error("no hold");
  // Hold and the increment gate both see access one edge late
  a_no_inc_held: assert property (
    time_hold_o |-> !time_inc_o) else $error("inc");
  a_read_answer: assert property (
    reg_rd_i |=> reg_rvalid_o) else $error("no answer");
  a_unmapped_zero: assert property (
    reg_rd_i && (reg_addr_i < 8'h0b || reg_addr_i > 8'h0f)
    |=> reg_rdata_o == 8'h00) else $error("unmapped data");
  a_flag_at_update: assert property (
    $rose(alarm_flag_o) |-> $past(time_inc_o, 2)) else $error("early");
  a_flag_holds: assert property (
    alarm_flag_o && !alarm_flag_clear_i |=> alarm_flag_o)
    else $error("flag lost");
  a_flag_clears: assert property (
    alarm_flag_clear_i && !$past(time_inc_o) |=> !alarm_flag_o)
    else $error("flag stuck");
  a_int_tracks: assert property (
    $stable(alarm_irq_enable_i)
    |-> int_oe_n_o == !(alarm_irq_enable_i && alarm_flag_o))
    else $error("pin");
endmodule

bind rta_core rta_core_properties i_rta_core_properties (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .access_active_i(access_active_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .alarm_irq_enable_i(alarm_irq_enable_i),
  .alarm_flag_clear_i(alarm_flag_clear_i), .time_hold_o(time_hold_o),
  .time_inc_o(time_inc_o), .alarm_flag_o(alarm_flag_o),
  .int_oe_n_o(int_oe_n_o));

// ---- verification/rta_host_model.sv ----
`timescale 1ns/10ps
// Host controller behind the serial front end
module rta_host_model
(
  // Clock
  input wire ref_clk_i,
  // Register port towards the core
  output logic access_o = 1'b0,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] addr_o = 8'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // Access frame, held until the caller closes it, even across two ticks
  task frame(input logic on);
    @(posedge ref_clk_i);
    #2 access_o = on;
  endtask

  // One byte: strobe held over exactly one sampling edge
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #2 {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
    @(posedge ref_clk_i);
    // Released lines show the inverse, never a stale value
    #2 {wr_o, rd_o, addr_o, wdata_o} = {2'b00, ~a, ~d};
  endtask

  // Whole time read in one frame from 04h, address stepping
  task burst;
    for (int i = 0; i < 7; i++)
      xfer(1'b0, 8'h04 + 8'(i), 8'h00);
  endtask
endmodule

// ---- verification/tb_rta_core.sv ----
`timescale 1ns/10ps
// Self-checking bench for the alarm and counter-blocking core
module tb_rta_core;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic tick = 1'b0;
  logic clr = 1'b0;
  logic h12 = 1'b0;
  logic alarm_irq_enable = 1'b0;
  // Second, minute, hour, date, weekday
  logic [7:0] tv [5] = '{default: 8'h00};
  wire acc, wr, rd, rvalid, hold, inc, flag, oe_n, int_pin;
  wire [7:0] addr, wdata, rdata;
  // Expected read answers, oldest first
  logic [7:0] expq [$];
  int seed = 37;
  int bad_count = 0;
  int cmp_count = 0;
  int inc_cnt = 0;

  rta_host_model i_rta_host_model (.ref_clk_i(ref_clk_i), .access_o(acc),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  rta_core i_rta_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .tick_1hz_i(tick), .access_active_i(acc), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .time_sec_i(tv[0]), .time_min_i(tv[1]),
    .time_hr_i(tv[2]), .time_date_i(tv[3]), .time_dow_i(tv[4]),
    .hour_12_mode_i(h12), .alarm_irq_enable_i(alarm_irq_enable),
    .alarm_flag_clear_i(clr), .time_hold_o(hold), .time_inc_o(inc),
    .alarm_flag_o(flag), .int_o(int_pin), .int_oe_n_o(oe_n));

  initial
  begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task step;
    @(posedge ref_clk_i);
    #2;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Register read; task names kept apart from the strobe nets
  task rreg(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_rta_host_model.xfer(1'b0, a, 8'h00);
  endtask

  task wreg(input logic [7:0] a, input logic [7:0] d);
    i_rta_host_model.xfer(1'b1, a, d);
  endtask

  // Optional tick, then a bounded wait for one more increment
  task update(input logic t);
    int n;
    n = inc_cnt + 1;
    if (t)
    begin
      tick = 1'b1;
      repeat (4) step;
      tick = 1'b0;
    end
    for (int k = 0; k < 40 && inc_cnt < n; k++)
      step;
    if (inc_cnt != n)
    begin
      check(8'(inc_cnt), 8'(n));
      summarize;
    end
    repeat (4) step;
  endtask

  task clear_flag;
    clr = 1'b1;
    step;
    clr = 1'b0;
    step;
  endtask

  // Random BCD value with tens below hi
  function automatic logic [7:0] bcd(input int hi);
    int r;
    r = $random(seed) & 32'h7fff_ffff;
    return {1'b0, 3'(r / 10 % hi), 4'(r % 10)};
  endfunction

  // Counts increments and takes each read answer off the queue
  always @(negedge ref_clk_i)
  begin
    if (inc === 1'b1)
      inc_cnt++;
    if (rvalid === 1'b1)
      check(rdata, expq.size() > 0 ? expq.pop_front() : 8'hxx);
  end

  initial
  begin
    repeat (10) step;
    rst_n_i = 1'b1;
    for (int i = 0; i < 5; i++)
      rreg(8'h0b + 8'(i), 8'h80);
    rreg(8'h10, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wreg(8'h0b + 8'(i), 8'hff);
      rreg(8'h0b + 8'(i), i < 2 ? 8'hff : i < 4 ? 8'hbf : 8'h87);
    end
    $display("register test done");
    // Two ticks inside one frame give a single late increment
    i_rta_host_model.frame(1'b1);
    repeat (2)
    begin
      tick = 1'b1;
      repeat (4) step;
      tick = 1'b0;
      repeat (4) step;
    end
    check(8'(inc_cnt), 8'h00);
    check(8'(hold), 8'h01);
    for (int i = 0; i < 7; i++)
      expq.push_back(8'h00);
    i_rta_host_model.burst;
    i_rta_host_model.frame(1'b0);
    update(1'b0);
    repeat (12) step;
    check(8'(inc_cnt), 8'h01);
    check(8'(hold), 8'h00);
    $display("blocking test done");
    tv = '{bcd(6), bcd(6), 8'h21, bcd(4), 8'(bcd(7) % 8'h07)};
    alarm_irq_enable = 1'b1;
    for (int i = 0; i < 5; i++)
      wreg(8'h0b + 8'(i), tv[i]);
    update(1'b1);
    check(8'(flag), 8'h01);
    check(8'(oe_n), 8'h00);
    check(8'(int_pin), 8'h00);
    clear_flag;
    check(8'(flag), 8'h00);
    tv[0] = tv[0] ^ 8'h01;
    update(1'b1);
    check(8'(flag), 8'h00);
    wreg(8'h0b, 8'h80 | (tv[0] ^ 8'h01));
    update(1'b1);
    check(8'(flag), 8'h01);
    clear_flag;
    for (int m = 0; m < 2; m++)
    begin
      h12 = m[0];
      alarm_irq_enable = !m[0];
      update(1'b1);
      check(8'(flag), 8'h01);
      check(8'(oe_n), 8'(m));
      clear_flag;
    end
    check(8'(expq.size()), 8'h00);
    $display("alarm test done");
    summarize;
  end
endmodule
